// ---- design/lpg_checker.sv ----
// receive pattern checker with its control block and error counter
`timescale 1ns/100ps
`default_nettype none
`include "lpg_map.svh"
module lpg_checker
  import lpg_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // register side
  lpg_chk_if.chk    bus
);

  lpg_chk_state_type state_ff;
  lpg_chk_state_type nxt_state;
  logic [30:0]       lfsr_ff;
  logic [30:0]       nxt_lfsr;
  logic [2:0]        idx_ff;
  logic [2:0]        nxt_idx;
  logic [2:0]        warm_ff;
  logic [15:0]       err_ff;
  logic              mism;
  logic [9:0]        unit;
  logic [9:0]        expv;

  ////////////////////////////////////////////////////////////////////////
  // compare one received word; the lfsr reloads from received bits
  always_comb begin
    mism     = 1'b0;
    nxt_lfsr = lfsr_ff;
    nxt_idx  = idx_ff;
    unit     = '0;
    expv     = '0;
    for (int u = 0; u < 2; u++) begin
      if (u == 0 || bus.dbl) begin
        unit = lpg_slice({20'h0, bus.rx_data}, 3'(u), bus.byte_mode);
        if (!bus.kind) begin
          // k flag taken as zero in byte mode
          expv = lpg_slice(bus.udp, nxt_idx, bus.byte_mode);
          mism = mism | (expv != unit);
          if (nxt_idx == (bus.byte_mode ? 3'h4 : 3'h3)) begin
            nxt_idx = 3'h0;
          end else begin
            nxt_idx = nxt_idx + 3'h1;
          end
        end else begin
          for (int b = 0; b < 10; b++) begin
            if (b < (bus.byte_mode ? 8 : 10)) begin
              mism = mism | (lpg_prbs_fb(nxt_lfsr, bus.prbs_sel) != unit[b]);
              nxt_lfsr = {nxt_lfsr[29:0], unit[b]};
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control block: arms on enable; PRBS runs after LPG_PRBS_WARM valid words, the user pattern runs at once
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LPG_CHK_IDLE: begin
        if (bus.enable) begin
          nxt_state = bus.kind ? LPG_CHK_WAIT : LPG_CHK_RUN;
        end
      end
      LPG_CHK_WAIT: begin
        if (!bus.enable) begin
          nxt_state = LPG_CHK_IDLE;
        end else if (bus.rx_valid && warm_ff == `LPG_PRBS_WARM - 3'h1) begin
          nxt_state = LPG_CHK_RUN;
        end
      end
      LPG_CHK_RUN: begin
        if (!bus.enable) begin
          nxt_state = LPG_CHK_IDLE;
        end
      end
      default: nxt_state = LPG_CHK_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= LPG_CHK_IDLE;
      warm_ff  <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != LPG_CHK_WAIT) begin
        warm_ff <= 3'h0;
      end else if (bus.rx_valid) begin
        warm_ff <= warm_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_ff <= `LPG_PRBS_SEED;
      idx_ff  <= 3'h0;
    end else if (state_ff == LPG_CHK_IDLE) begin
      idx_ff <= 3'h0;
    end else if (bus.rx_valid) begin
      lfsr_ff <= nxt_lfsr;
      idx_ff  <= nxt_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error counter; clear acts directly, whatever the control state
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear) begin
      err_ff <= 16'h0000;
    end else if (state_ff == LPG_CHK_RUN && bus.rx_valid && mism &&
                 err_ff != 16'hFFFF) begin
      err_ff <= err_ff + 16'h0001;
    end
  end

  assign bus.err_cnt = err_ff;
  assign bus.active  = (state_ff == LPG_CHK_RUN);

endmodule : lpg_checker
`default_nettype wire

// ---- design/lpg_chk_if.sv ----
// signals between the register side and the pattern checker
`timescale 1ns/100ps
`default_nettype none
interface lpg_chk_if;
  logic        byte_mode;
  logic        dbl;
  logic        kind;
  logic [1:0]  prbs_sel;
  logic [39:0] udp;
  logic        enable;
  logic        clear;
  logic [19:0] rx_data;
  logic        rx_valid;
  logic [15:0] err_cnt;
  logic        active;

  modport host(output byte_mode, dbl, kind, prbs_sel, udp, enable, clear,
               output rx_data, rx_valid, input err_cnt, active);
  modport chk(input byte_mode, dbl, kind, prbs_sel, udp, enable, clear,
              input rx_data, rx_valid, output err_cnt, active);
endinterface : lpg_chk_if
`default_nettype wire

// ---- design/lpg_map.svh ----
// register map, field positions and reset values of the lane self-test block
`ifndef LPG_MAP_SVH
`define LPG_MAP_SVH

// byte offsets on the register bus
`define LPG_OFS_MODE 8'h30
`define LPG_OFS_GEN  8'h34
`define LPG_OFS_UDP  8'h38
`define LPG_OFS_INSW 8'h3C
`define LPG_OFS_ENLO 8'h40
`define LPG_OFS_IDLY 8'h44
`define LPG_OFS_CAL  8'h48
`define LPG_OFS_CHK  8'h4C

// writable bits; all others are reserved and read zero, except CAL bits 15:0, which read the checker error count
`define LPG_MSK_MODE 32'hFFFD3800
`define LPG_MSK_GEN  32'h7803FFFF
`define LPG_MSK_FULL 32'hFFFFFFFF
`define LPG_MSK_IDLY 32'h0FFFFFFF
`define LPG_MSK_CAL  32'h20FF0000
`define LPG_MSK_CHK  32'h00000003
`define LPG_RST_WORD 32'h00000000

// lane_selftest_mode_cfg fields
`define LPG_M_PRE0L  31:24
`define LPG_M_RXCKEN 23
`define LPG_M_TXCKEN 22
`define LPG_M_PRBS   20:19
`define LPG_M_KIND   18
`define LPG_M_BYTE   16
`define LPG_M_AGAIN  13:12
`define LPG_M_ADIS   11

// lane_generator_ctrl fields
`define LPG_G_ICNT   30:28
`define LPG_G_PRE    27
`define LPG_G_PRE1   17:8
`define LPG_G_EN     7
`define LPG_G_DBL    6
`define LPG_G_RSTN   5
`define LPG_G_ISZ    4:2
`define LPG_G_PRE0H  1:0

// split fields of the pattern words
`define LPG_I_INSL   31:8
`define LPG_I_UDPH   7:0
`define LPG_E_LOW    31:16
`define LPG_E_INSH   15:0
`define LPG_D_DELAY  27:16
`define LPG_D_HIGH   15:0
`define LPG_C_LATCH  29
`define LPG_C_DATA   23:17
`define LPG_C_EN     16
`define LPG_C_ERR    15:0
`define LPG_K_EN     0
`define LPG_K_CLR    1

// generator constants
`define LPG_PRBS_SEED 31'h7FFFFFFF
`define LPG_PRBS_WARM 3'h4
`define LPG_INS_MAXLEN 3'h4

`endif

// ---- design/lpg_pkg.sv ----
// types and shared functions of the lane self-test block
`default_nettype none
package lpg_pkg;

  typedef enum logic [1:0] {
    LPG_CHK_IDLE = 2'b00,
    LPG_CHK_WAIT = 2'b01,
    LPG_CHK_RUN  = 2'b10
  } lpg_chk_state_type;

  typedef enum logic [1:0] {
    LPG_OE_IDLE = 2'b00,
    LPG_OE_LOW  = 2'b01,
    LPG_OE_HIGH = 2'b10
  } lpg_oe_state_type;

  // feedback bit of PRBS7/15/23/31, Fibonacci form
  function automatic logic lpg_prbs_fb(input logic [30:0] s,
                                       input logic [1:0]  sel);
    case (sel)
      2'h0:    lpg_prbs_fb = s[6] ^ s[5];
      2'h1:    lpg_prbs_fb = s[14] ^ s[13];
      2'h2:    lpg_prbs_fb = s[22] ^ s[17];
      default: lpg_prbs_fb = s[30] ^ s[27];
    endcase
  endfunction : lpg_prbs_fb

  // one 10-bit unit, or one 8-bit unit zero-extended in byte mode
  function automatic logic [9:0] lpg_slice(input logic [39:0] w,
                                           input logic [2:0]  idx,
                                           input logic        byt);
    if (byt) begin
      lpg_slice = {2'h0, w[idx*8 +: 8]};
    end else begin
      lpg_slice = w[idx*10 +: 10];
    end
  endfunction : lpg_slice

endpackage : lpg_pkg
`default_nettype wire

// ---- design/lpg_top.sv ----
// lane pattern generator and checker with its register file
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "lpg_map.svh"
module lpg_top
  import lpg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // generator stream
  output logic      [19:0] gen_data_o,
  output logic      [1:0]  gen_k_o,
  output logic             gen_oe_o,
  output logic             gen_active_o,
  output logic             tx_bist_clk_en_o,
  // receive stream to check
  input  wire logic [19:0] rx_data_i,
  input  wire logic        rx_valid_i,
  output logic             chk_active_o,
  output logic             rx_bist_clk_en_o,
  // calibration overrides
  input  wire logic [1:0]  att_gain_auto_i,
  output logic      [1:0]  att_gain_o,
  input  wire logic [6:0]  cal_data_i,
  input  wire logic        cal_latch_i,
  output logic      [6:0]  cal_data_o,
  output logic             cal_latch_o,
  output logic             cal_ovr_en_o
);

  logic [31:0]      mode_ff;
  logic [31:0]      gen_ff;
  logic [31:0]      udp_ff;
  logic [31:0]      insw_ff;
  logic [31:0]      enlo_ff;
  logic [31:0]      idly_ff;
  logic [31:0]      cal_ff;
  logic [31:0]      chk_ff;
  logic             ack_ff;
  logic [31:0]      rdat_ff;
  logic [31:0]      nxt_rdat;
  logic             wr_en;
  lpg_chk_if        chk_bus ();

  // byte-lane merge with the writable mask
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] msk);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) begin
        v[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    wb_merge = v & msk;
  endfunction : wb_merge

  ////////////////////////////////////////////////////////////////////////
  // bus slave: ack one cycle after the request, write on the ack edge
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
    end
  end

  always_comb begin
    if (wb_adr_i == `LPG_OFS_MODE) begin
      nxt_rdat = mode_ff;
    end else if (wb_adr_i == `LPG_OFS_GEN) begin
      nxt_rdat = gen_ff;
    end else if (wb_adr_i == `LPG_OFS_UDP) begin
      nxt_rdat = udp_ff;
    end else if (wb_adr_i == `LPG_OFS_INSW) begin
      nxt_rdat = insw_ff;
    end else if (wb_adr_i == `LPG_OFS_ENLO) begin
      nxt_rdat = enlo_ff;
    end else if (wb_adr_i == `LPG_OFS_IDLY) begin
      nxt_rdat = idly_ff;
    end else if (wb_adr_i == `LPG_OFS_CAL) begin
      nxt_rdat = {cal_ff[31:16], chk_bus.err_cnt};
    end else if (wb_adr_i == `LPG_OFS_CHK) begin
      nxt_rdat = chk_ff;
    end else begin
      // unmapped: acknowledged, reads zero
      nxt_rdat = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= `LPG_RST_WORD;
      gen_ff  <= `LPG_RST_WORD;
      udp_ff  <= `LPG_RST_WORD;
      insw_ff <= `LPG_RST_WORD;
      enlo_ff <= `LPG_RST_WORD;
      idly_ff <= `LPG_RST_WORD;
      cal_ff  <= `LPG_RST_WORD;
      chk_ff  <= `LPG_RST_WORD;
    end else if (wr_en) begin
      if (wb_adr_i == `LPG_OFS_MODE) begin
        mode_ff <= wb_merge(mode_ff, `LPG_MSK_MODE);
      end else if (wb_adr_i == `LPG_OFS_GEN) begin
        gen_ff <= wb_merge(gen_ff, `LPG_MSK_GEN);
      end else if (wb_adr_i == `LPG_OFS_UDP) begin
        udp_ff <= wb_merge(udp_ff, `LPG_MSK_FULL);
      end else if (wb_adr_i == `LPG_OFS_INSW) begin
        insw_ff <= wb_merge(insw_ff, `LPG_MSK_FULL);
      end else if (wb_adr_i == `LPG_OFS_ENLO) begin
        enlo_ff <= wb_merge(enlo_ff, `LPG_MSK_FULL);
      end else if (wb_adr_i == `LPG_OFS_IDLY) begin
        idly_ff <= wb_merge(idly_ff, `LPG_MSK_IDLY);
      end else if (wb_adr_i == `LPG_OFS_CAL) begin
        cal_ff <= wb_merge(cal_ff, `LPG_MSK_CAL);
      end else if (wb_adr_i == `LPG_OFS_CHK) begin
        chk_ff <= wb_merge(chk_ff, `LPG_MSK_CHK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // generator fields
  logic        byte_mode;
  logic        dbl;
  logic        run;
  logic        gen_rst;
  logic [39:0] ins_word;
  logic [9:0]  pre0;
  logic [9:0]  pre1;
  logic [2:0]  ins_len;
  logic [2:0]  ins_cnt;
  logic        ins_on;
  logic [4:0]  ins_total;

  assign byte_mode = mode_ff[`LPG_M_BYTE];
  assign dbl       = gen_ff[`LPG_G_DBL];
  assign gen_rst   = rst_i | ~gen_ff[`LPG_G_RSTN];
  assign run       = gen_ff[`LPG_G_EN];
  assign ins_word  = {enlo_ff[`LPG_E_INSH], insw_ff[`LPG_I_INSL]};
  assign pre0      = {gen_ff[`LPG_G_PRE0H], mode_ff[`LPG_M_PRE0L]};
  assign pre1      = gen_ff[`LPG_G_PRE1];
  assign ins_len   = gen_ff[`LPG_G_ISZ];
  assign ins_cnt   = gen_ff[`LPG_G_ICNT];
  // codes above four are treated as no insertion
  assign ins_on    = ins_cnt != 3'h0 && ins_len != 3'h0 &&
                     ins_len <= `LPG_INS_MAXLEN;
  assign ins_total = {2'h0, ins_cnt} * {2'h0, ins_len};

  // generator state
  logic [30:0]      lfsr_ff;
  logic [30:0]      nxt_lfsr;
  logic             pre_sel_ff;
  logic             nxt_pre_sel;
  logic [4:0]       left_ff;
  logic [4:0]       nxt_left;
  logic [2:0]       idx_ff;
  logic [2:0]       nxt_idx;
  logic [11:0]      gap_ff;
  logic [11:0]      nxt_gap;
  logic [1:0][9:0]  unit_v;
  logic [19:0]      nxt_data;
  logic [1:0]       nxt_k;

  ////////////////////////////////////////////////////////////////////////
  // per unit: insertion first, then preamble or PRBS data
  always_comb begin
    nxt_lfsr    = lfsr_ff;
    nxt_pre_sel = pre_sel_ff;
    nxt_left    = left_ff;
    nxt_idx     = idx_ff;
    nxt_gap     = gap_ff;
    unit_v      = '0;
    for (int u = 0; u < 2; u++) begin
      if (u == 0 || dbl) begin
        if (nxt_left != 5'h0) begin
          unit_v[u] = lpg_slice(ins_word, nxt_idx, 1'b0);
          nxt_left  = nxt_left - 5'h1;
          nxt_idx   = (nxt_idx == ins_len - 3'h1) ? 3'h0 : nxt_idx + 3'h1;
        end else if (ins_on && nxt_gap >= idly_ff[`LPG_D_DELAY]) begin
          unit_v[u] = lpg_slice(ins_word, 3'h0, 1'b0);
          nxt_left  = ins_total - 5'h1;
          nxt_idx   = (ins_len == 3'h1) ? 3'h0 : 3'h1;
          nxt_gap   = 12'h000;
        end else begin
          if (nxt_gap != 12'hFFF) begin
            nxt_gap = nxt_gap + 12'h001;
          end
          if (gen_ff[`LPG_G_PRE]) begin
            unit_v[u]   = nxt_pre_sel ? pre1 : pre0;
            nxt_pre_sel = ~nxt_pre_sel;
          end else begin
            for (int b = 0; b < 10; b++) begin
              if (b < (byte_mode ? 8 : 10)) begin
                unit_v[u][b] = lpg_prbs_fb(nxt_lfsr, mode_ff[`LPG_M_PRBS]);
                nxt_lfsr = {nxt_lfsr[29:0], unit_v[u][b]};
              end
            end
          end
        end
      end
    end
    // byte mode packs two bytes, bit 8 of each unit is its K flag
    if (byte_mode) begin
      nxt_data = {4'h0, unit_v[1][7:0], unit_v[0][7:0]};
      nxt_k    = {unit_v[1][8], unit_v[0][8]};
    end else begin
      nxt_data = {unit_v[1], unit_v[0]};
      nxt_k    = 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (gen_rst) begin
      lfsr_ff    <= `LPG_PRBS_SEED;
      pre_sel_ff <= 1'b0;
      left_ff    <= 5'h00;
      idx_ff     <= 3'h0;
      gap_ff     <= 12'h000;
    end else if (run) begin
      lfsr_ff    <= nxt_lfsr;
      pre_sel_ff <= nxt_pre_sel;
      left_ff    <= nxt_left;
      idx_ff     <= nxt_idx;
      gap_ff     <= nxt_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output enable pattern; the counter includes the current word
  lpg_oe_state_type oe_state_ff;
  lpg_oe_state_type nxt_oe_state;
  logic [15:0]      oe_cnt_ff;
  logic [15:0]      nxt_oe_cnt;
  logic [15:0]      en_low;
  logic [15:0]      en_high;

  assign en_low  = enlo_ff[`LPG_E_LOW];
  assign en_high = idly_ff[`LPG_D_HIGH];

  always_comb begin
    nxt_oe_state = oe_state_ff;
    nxt_oe_cnt   = oe_cnt_ff;
    case (oe_state_ff)
      LPG_OE_IDLE: begin
        if (en_low == 16'h0000) begin
          nxt_oe_state = LPG_OE_HIGH;
        end else begin
          nxt_oe_state = LPG_OE_LOW;
        end
        nxt_oe_cnt = 16'h0001;
      end
      LPG_OE_LOW: begin
        if (oe_cnt_ff < en_low) begin
          nxt_oe_cnt = oe_cnt_ff + 16'h0001;
        end else begin
          // a zero high period goes straight back to low
          nxt_oe_state = (en_high == 16'h0000) ? LPG_OE_LOW : LPG_OE_HIGH;
          nxt_oe_cnt   = 16'h0001;
        end
      end
      LPG_OE_HIGH: begin
        if (en_low == 16'h0000) begin
          nxt_oe_cnt = 16'h0001;
        end else if (oe_cnt_ff >= en_high) begin
          nxt_oe_state = LPG_OE_LOW;
          nxt_oe_cnt   = 16'h0001;
        end else begin
          nxt_oe_cnt = oe_cnt_ff + 16'h0001;
        end
      end
      default: nxt_oe_state = LPG_OE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (gen_rst || !run) begin
      oe_state_ff <= LPG_OE_IDLE;
      oe_cnt_ff   <= 16'h0000;
    end else begin
      oe_state_ff <= nxt_oe_state;
      oe_cnt_ff   <= nxt_oe_cnt;
    end
  end

  // stream outputs; idle generator drives zeros
  always_ff @(posedge clk_i) begin
    if (gen_rst || !run) begin
      gen_data_o   <= 20'h00000;
      gen_k_o      <= 2'h0;
      gen_oe_o     <= 1'b0;
      gen_active_o <= 1'b0;
    end else begin
      gen_data_o   <= nxt_data;
      gen_k_o      <= nxt_k;
      gen_oe_o     <= (nxt_oe_state == LPG_OE_HIGH);
      gen_active_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checker
  assign chk_bus.byte_mode = byte_mode;
  assign chk_bus.dbl       = dbl;
  assign chk_bus.kind      = mode_ff[`LPG_M_KIND];
  assign chk_bus.prbs_sel  = mode_ff[`LPG_M_PRBS];
  assign chk_bus.udp       = {insw_ff[`LPG_I_UDPH], udp_ff};
  assign chk_bus.enable    = chk_ff[`LPG_K_EN];
  assign chk_bus.clear     = chk_ff[`LPG_K_CLR];
  assign chk_bus.rx_data   = rx_data_i;
  assign chk_bus.rx_valid  = rx_valid_i;

  lpg_checker u_checker (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (chk_bus.chk)
  );

  ////////////////////////////////////////////////////////////////////////
  // calibration overrides and misc registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      att_gain_o       <= 2'h0;
      cal_data_o       <= 7'h00;
      cal_latch_o      <= 1'b0;
      cal_ovr_en_o     <= 1'b0;
      chk_active_o     <= 1'b0;
      tx_bist_clk_en_o <= 1'b0;
      rx_bist_clk_en_o <= 1'b0;
    end else begin
      att_gain_o <= mode_ff[`LPG_M_ADIS] ? mode_ff[`LPG_M_AGAIN]
                                         : att_gain_auto_i;
      cal_ovr_en_o <= cal_ff[`LPG_C_EN];
      cal_data_o   <= cal_ff[`LPG_C_EN] ? cal_ff[`LPG_C_DATA]
                                        : cal_data_i;
      cal_latch_o  <= cal_ff[`LPG_C_EN] ? cal_ff[`LPG_C_LATCH]
                                        : cal_latch_i;
      chk_active_o     <= chk_bus.active;
      tx_bist_clk_en_o <= mode_ff[`LPG_M_TXCKEN];
      rx_bist_clk_en_o <= mode_ff[`LPG_M_RXCKEN];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule : lpg_top
`default_nettype wire

// ---- sim/lpg_link_model.sv ----
// far side: lane loopback from generator to checker
`timescale 1ns/100ps
`default_nettype none
module lpg_link_model (
  // clock
  input  wire logic        clk_i,
  // generator side
  input  wire logic [19:0] tx_data_i,
  input  wire logic        tx_oe_i,
  // bench controls
  input  wire logic        err_i,
  input  wire logic        zero_i,
  // checker side
  output logic      [19:0] rx_data_o,
  output logic             rx_valid_o
);
  initial begin
    rx_data_o = 20'h0;
    rx_valid_o = 1'b0;
  end
  always @(posedge clk_i) begin
    rx_valid_o <= tx_oe_i | zero_i;
    if (zero_i) rx_data_o <= 20'h0;
    else if (tx_oe_i) rx_data_o <= tx_data_i ^ {19'h0, err_i};
    // released lane toggles, never a stale copy
    else rx_data_o <= ~rx_data_o;
  end
endmodule : lpg_link_model
`default_nettype wire

// ---- sim/lpg_top_properties.sv ----
// port-level checks of the lane self-test block
`timescale 1ns/100ps
`default_nettype none
module lpg_top_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // stream and overrides
  input wire logic [19:0] gen_data_o,
  input wire logic [1:0]  gen_k_o,
  input wire logic        gen_oe_o,
  input wire logic        gen_active_o,
  input wire logic        chk_active_o,
  input wire logic [6:0]  cal_data_i,
  input wire logic [6:0]  cal_data_o,
  input wire logic        cal_ovr_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  rdata_hold_a: assert property (!wb_stb_i |-> $stable(wb_dat_o))
    else $error("read data moved");
  idle_quiet_a: assert property
    (!gen_active_o && !$past(gen_active_o) |-> !gen_oe_o && gen_data_o == 0)
    else $error("idle generator drives");
  oe_active_a: assert property (gen_oe_o |-> gen_active_o)
    else $error("enable outside run");
  k_byte_pack_a: assert property
    (gen_k_o != 2'h0 |-> gen_data_o[19:16] == 4'h0)
    else $error("byte packing broken");
  // both copy timings of the override bit are accepted
  cal_pass_a: assert property
    (!cal_ovr_en_o && !$past(cal_ovr_en_o) && !$past(rst_i)
     |-> cal_data_o == $past(cal_data_i))
    else $error("calibration not passed");
  start_cause_a: assert property
    ($rose(gen_active_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("start without write");
  cover property (gen_oe_o && gen_k_o != 2'h0);
  cover property ($fell(gen_oe_o));
  cover property (chk_active_o);
endmodule : lpg_top_properties
bind lpg_top lpg_top_properties chk_u (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .gen_data_o, .gen_k_o, .gen_oe_o,
  .gen_active_o, .chk_active_o, .cal_data_i, .cal_data_o, .cal_ovr_en_o);
`default_nettype wire

// ---- sim/lpg_top_tb_top.sv ----
// bench: register tasks and stream scenarios
`timescale 1ns/100ps
`default_nettype none
`include "lpg_map.svh"
module lpg_top_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic        err = 1'b0, zro = 1'b0, latch_in = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  gain_in = 2'h1;
  logic [6:0]  cal_in = 7'h15;
  logic [39:0] ins = {10'h3F2, 10'h1E4, 10'h0D3, 10'h155};
  logic [7:0]  ofs [9] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44,
                           8'h48, 8'h4C, 8'h50};
  logic [31:0] msk [9] = '{`LPG_MSK_MODE, `LPG_MSK_GEN, `LPG_MSK_FULL,
    `LPG_MSK_FULL, `LPG_MSK_FULL, `LPG_MSK_IDLY, `LPG_MSK_CAL,
    `LPG_MSK_CHK, 32'h0};
  wire  [31:0] dat;
  wire  [19:0] gd, rxd;
  wire  [1:0]  gk, gain;
  wire  [6:0]  cal;
  wire         ack, oe, act, rxv, cact, lat, ove, tce, rce;
  int          fails = 0, cmp_count = 0;
  lpg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .gen_data_o(gd),
    .gen_k_o(gk), .gen_oe_o(oe), .gen_active_o(act),
    .tx_bist_clk_en_o(tce), .rx_data_i(rxd), .rx_valid_i(rxv),
    .chk_active_o(cact), .rx_bist_clk_en_o(rce), .att_gain_auto_i(gain_in),
    .att_gain_o(gain), .cal_data_i(cal_in), .cal_latch_i(latch_in),
    .cal_data_o(cal), .cal_latch_o(lat), .cal_ovr_en_o(ove));
  lpg_link_model link (.clk_i(clk_i), .tx_data_i(gd), .tx_oe_i(oe),
    .err_i(err), .zero_i(zro), .rx_data_o(rxd), .rx_valid_o(rxv));
  always #2 clk_i = ~clk_i;
  //////////////////////////////////////////
  task automatic ck(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: value differs", $time);
    end
  endtask : ck
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat;
    cyc <= 1'b0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    ck(rdat === e);
  endtask : rd
  task automatic hunt(input logic [19:0] w, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 64 && !hit; i++) begin
      @(posedge clk_i);
      hit = (gd === w);
    end
  endtask : hunt
  task automatic nxt(input logic [19:0] w);
    @(posedge clk_i);
    ck(gd === w);
  endtask : nxt
  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #60000;
    fails++;
    close_out();
  end
  initial begin
    logic hit;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    foreach (ofs[i]) begin
      acc(1'b1, ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], msk[i]);
    end
    repeat (2) @(posedge clk_i);
    ck(gain === 2'h3 && tce === 1'b1 && rce === 1'b1);
    ck(cal === 7'h7F && lat === 1'b1 && ove === 1'b1);
    foreach (ofs[i]) acc(1'b1, ofs[i], 32'h0);
    repeat (2) @(posedge clk_i);
    ck(gain === gain_in && cal === cal_in && lat === latch_in);
    $display("register test done");
    // pre0 carries the alignment character
    acc(1'b1, 8'h30, 32'h7C000000);
    acc(1'b1, 8'h34, 32'h08038320);
    repeat (4) @(posedge clk_i);
    ck(gd === 20'h0 && oe === 1'b0);
    acc(1'b1, 8'h34, 32'h08038380);
    repeat (4) @(posedge clk_i);
    ck(gd === 20'h0 && act === 1'b0);
    acc(1'b1, 8'h34, 32'h080383A0);
    hunt(20'h0007C, hit);
    ck(hit === 1'b1);
    nxt(20'h00383);
    nxt(20'h0007C);
    ck(oe === 1'b1);
    acc(1'b1, 8'h30, 32'hBC010000);
    acc(1'b1, 8'h34, 32'h0800AAE1);
    hunt(20'h0AABC, hit);
    ck(hit === 1'b1 && gk === 2'b01);
    nxt(20'h0AABC);
    $display("stream test done");
    acc(1'b1, 8'h30, 32'h7C000000);
    acc(1'b1, 8'h3C, {ins[23:0], 8'h00});
    acc(1'b1, 8'h40, {16'h0, ins[39:24]});
    acc(1'b1, 8'h44, 32'h00030000);
    for (int n = 0; n < 5; n++) begin
      acc(1'b1, 8'h34, 32'h0);
      acc(1'b1, 8'h34, 32'h180383A0 | (n << 2));
      hunt({10'h0, ins[9:0]}, hit);
      ck(hit === (n != 0));
      for (int k = 1; k < n; k++) nxt({10'h0, ins[k*10 +: 10]});
      if (n != 0) begin
        repeat (3) begin
          @(posedge clk_i);
          ck(gd !== {10'h0, ins[9:0]});
        end
        nxt({10'h0, ins[9:0]});
      end
    end
    $display("insertion test done");
    acc(1'b1, 8'h40, {16'h0002, ins[39:24]});
    acc(1'b1, 8'h44, 32'h00020003);
    acc(1'b1, 8'h34, 32'h080383A0);
    for (int i = 0; i < 20 && oe !== 1'b0; i++) @(posedge clk_i);
    for (int i = 0; i < 20 && oe !== 1'b1; i++) @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      ck(oe === (i < 3 || i == 5));
      @(posedge clk_i);
    end
    acc(1'b1, 8'h40, {16'h0, ins[39:24]});
    $display("enable period test done");
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 8'h30, 32'h7C040000 | (s << 19));
      acc(1'b1, 8'h34, 32'h000000E0);
      acc(1'b1, 8'h4C, 32'h1);
      repeat (40) @(posedge clk_i);
      ck(cact === 1'b1);
      rd(8'h48, 32'h0);
      err <= 1'b1;
      @(posedge clk_i);
      err <= 1'b0;
      repeat (20) @(posedge clk_i);
      acc(1'b0, 8'h48, 32'h0);
      ck(rdat[15:0] > 16'h0 && rdat[15:0] < 16'h5);
      acc(1'b1, 8'h4C, 32'h3);
      rd(8'h48, 32'h0);
      acc(1'b1, 8'h4C, 32'h0);
    end
    acc(1'b1, 8'h30, 32'h7C000000);
    acc(1'b1, 8'h34, 32'h0);
    zro <= 1'b1;
    acc(1'b1, 8'h4C, 32'h1);
    repeat (20) @(posedge clk_i);
    rd(8'h48, 32'h0);
    acc(1'b1, 8'h38, 32'h1);
    repeat (20) @(posedge clk_i);
    acc(1'b0, 8'h48, 32'h0);
    ck(rdat[15:0] !== 16'h0);
    $display("checker test done");
    close_out();
  end
endmodule : lpg_top_tb_top
`default_nettype wire
